// [design/alarm_status_pkg.sv]
// Constants and carrier types of the alarm status block.
// Assumes one 100 MHz clock and a word-wide Avalon-MM slave port.
package alarm_status_pkg;

	// ----------------------------------------------------------------
	// Register map (index; byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 10;
	localparam logic [7:0] IDX_CTRL = 8'h4D;
	localparam logic [7:0] IDX_MASK = 8'h4E;
	localparam logic [7:0] IDX_STATUS = 8'h4F;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic [15:0] STATUS_USED = 16'h7FFC;
	localparam logic [15:0] CTRL_WMASK = 16'h003D;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int IN0_FLAG = 14, IN1_FLAG = 13, IN2_FLAG = 12, IN3_FLAG = 11;
	localparam int DIE_UNDER = 10, DIE_OVER = 9, RA_UNDER = 8, RA_OVER = 7;
	localparam int RB_UNDER = 6, RB_OVER = 5, RA_FAULT = 4, RB_FAULT = 3;
	localparam int OVERHEAT = 2;

	// ----------------------------------------------------------------
	// Control bit positions
	// ----------------------------------------------------------------
	localparam int CTRL_OUT_EN = 0, CTRL_HOLD_OFF = 2, CTRL_DIE_ON = 3;
	localparam int CTRL_RA_ON = 4, CTRL_RB_ON = 5, CTRL_SOFT_RST = 15;

	// ----------------------------------------------------------------
	// Overheat limits in whole degrees C
	// ----------------------------------------------------------------
	localparam int OVERHEAT_C = 150;
	localparam int OVERHEAT_HYST_C = 8;

	// Avalon-MM request from the master
	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} av_req_t;

	// Raw range results of one conversion cycle
	typedef struct packed {
		logic [3:0] input_oor;
		logic die_under;
		logic die_over;
		logic ra_under;
		logic ra_over;
		logic rb_under;
		logic rb_over;
		logic ra_fault;
		logic rb_fault;
	} check_t;

endpackage : alarm_status_pkg

// [design/alarm_status_flags.sv]
// Alarm status flags with N-consecutive qualification and alarm pin.
// Assumes range results arrive with a one-cycle strobe per conversion
// cycle, and an Avalon-MM master that holds requests until answered.
//
// Contract
// - Check every channel on each conversion cycle
// - Flag sets after N consecutive out-of-range checks
// - In-range check restarts count, flag stays clear
// - Latched flag holds until fault ends and read; code clears it on a status read even while the fault persists
// - Status read clears all flags together; code keeps a flag whose qualifying check lands on the read's completing edge
// - Persisting fault sets flag again next cycle
// - Only resets, qualified read, hold-off mode and die sensor off (overheat only) clear flags
// - Hold-off mode: flag follows live condition
// - Bit 15 reads zero, writes ignored, resets zero
// - Bit 14 flags input 0 or pair 0/1
// - Bit 13 flags input 1
// - Bit 12 flags input 2 or pair 2/3
// - Bit 11 flags input 3
// - Bits 10 and 9: die under, over
// - Die flags checked only while die sensor on
// - Bits 8 and 7: remote A under, over
// - Remote A flags checked only while enabled
// - Bit 6: remote B under, when enabled
// - Bit 5: remote B over, when enabled
// - Bits 4, 3: remote sensor faults, when enabled
// - Bit 2: overheat at 150 C, 8 C hysteresis
// - Masked alarms set flags but not pin
//
// Register access over Avalon-MM was decided locally.
module alarm_status_flags #(
	parameter int unsigned CHECK_COUNT = 4,
	parameter int unsigned TEMP_W = 12
) (
	input wire logic clk, // 100 MHz clock
	input wire logic sys_rst, // Sync reset, active high
	input wire alarm_status_pkg::av_req_t av_req, // Avalon request
	output logic [31:0] av_readdata, // Avalon read data
	output logic av_waitrequest, // Avalon wait request
	input wire logic check_strobe, // New range results ready
	input wire alarm_status_pkg::check_t checks, // Raw range results
	input wire logic signed [TEMP_W-1:0] die_temp, // Die temp, whole deg C
	output logic alarm_n // Alarm pin, active low
);

	// ----------------------------------------------------------------
	// Derived constants and parameter checks
	// ----------------------------------------------------------------
	localparam int unsigned CW = $clog2(CHECK_COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(CHECK_COUNT - 1);
	localparam logic signed [TEMP_W-1:0] HOT_ON = TEMP_W'(alarm_status_pkg::OVERHEAT_C);
	localparam logic signed [TEMP_W-1:0] HOT_OFF =
		TEMP_W'(alarm_status_pkg::OVERHEAT_C - alarm_status_pkg::OVERHEAT_HYST_C);

	generate
		if (CHECK_COUNT < 1 || TEMP_W < 9 || TEMP_W > 16) begin : g_bad_param
			$error("alarm_status_flags: unsupported parameter value");
		end
	endgenerate

	// Register index match on a byte address
	function automatic logic reg_sel(input logic [alarm_status_pkg::ADDR_W-1:0] a,
		input logic [7:0] idx);
		return a[alarm_status_pkg::ADDR_W-1:2] == idx;
	endfunction : reg_sel

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be, input logic [15:0] wmask);
		logic [15:0] n;
		n = old;
		if (be[0]) begin
			n[7:0] = wd[7:0];
		end
		if (be[1]) begin
			n[15:8] = wd[15:8];
		end
		return n & wmask;
	endfunction : lane_merge

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] ctrl_q;
	logic [15:0] mask_q;
	logic [15:0] flag_q;
	logic [15:0] flag_d;
	logic [15:0] cond;
	logic [15:0] hit;
	logic [15:0] clr;
	logic [CW-1:0] cnt_q [16];
	logic hot_q;
	logic hot_now;
	logic soft_q;
	logic done;
	logic rd_clr;
	logic hold_off;
	logic die_on;
	logic ra_on;
	logic rb_on;

	assign hold_off = ctrl_q[alarm_status_pkg::CTRL_HOLD_OFF];
	assign die_on = ctrl_q[alarm_status_pkg::CTRL_DIE_ON];
	assign ra_on = ctrl_q[alarm_status_pkg::CTRL_RA_ON];
	assign rb_on = ctrl_q[alarm_status_pkg::CTRL_RB_ON];

	// ----------------------------------------------------------------
	// Avalon slave
	// ----------------------------------------------------------------
	// Completing edge of a request
	assign done = (av_req.read | av_req.write) & ~av_waitrequest;
	assign rd_clr = done & av_req.read & reg_sel(av_req.address, alarm_status_pkg::IDX_STATUS);

	// One wait cycle, then one answer cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			av_waitrequest <= 1'b1;
		end else begin
			av_waitrequest <= ~((av_req.read | av_req.write) & av_waitrequest);
		end
	end

	// Read data loaded one cycle before the answer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			av_readdata <= 32'h0000_0000;
		end else if (av_req.read & av_waitrequest) begin
			av_readdata <= 32'h0000_0000;
			if (reg_sel(av_req.address, alarm_status_pkg::IDX_STATUS)) begin
				av_readdata[15:0] <= flag_q & alarm_status_pkg::STATUS_USED;
			end else if (reg_sel(av_req.address, alarm_status_pkg::IDX_CTRL)) begin
				av_readdata[15:0] <= ctrl_q;
			end else if (reg_sel(av_req.address, alarm_status_pkg::IDX_MASK)) begin
				av_readdata[15:0] <= mask_q;
			end
		end
	end

	// Control and mask writes; status ignores writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q <= alarm_status_pkg::CTRL_RST;
			mask_q <= alarm_status_pkg::MASK_RST;
			soft_q <= 1'b0;
		end else begin
			soft_q <= 1'b0;
			if (done & av_req.write) begin
				if (reg_sel(av_req.address, alarm_status_pkg::IDX_CTRL)) begin
					ctrl_q <= lane_merge(ctrl_q, av_req.writedata, av_req.byteenable,
						alarm_status_pkg::CTRL_WMASK);
					soft_q <= av_req.byteenable[1] & av_req.writedata[alarm_status_pkg::CTRL_SOFT_RST];
				end
				if (reg_sel(av_req.address, alarm_status_pkg::IDX_MASK)) begin
					mask_q <= lane_merge(mask_q, av_req.writedata, av_req.byteenable,
						alarm_status_pkg::STATUS_USED);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Channel conditions
	// ----------------------------------------------------------------
	// Overheat with hysteresis
	assign hot_now = (die_temp >= HOT_ON) | (hot_q & (die_temp >= HOT_OFF));

	always_ff @(posedge clk) begin
		if (sys_rst | soft_q) begin
			hot_q <= 1'b0;
		end else if (check_strobe) begin
			hot_q <= hot_now & die_on;
		end
	end

	// Map raw results onto status positions, gated by sensor enables
	always_comb begin
		cond = 16'h0000;
		cond[alarm_status_pkg::IN0_FLAG] = checks.input_oor[0];
		cond[alarm_status_pkg::IN1_FLAG] = checks.input_oor[1];
		cond[alarm_status_pkg::IN2_FLAG] = checks.input_oor[2];
		cond[alarm_status_pkg::IN3_FLAG] = checks.input_oor[3];
		cond[alarm_status_pkg::DIE_UNDER] = checks.die_under & die_on;
		cond[alarm_status_pkg::DIE_OVER] = checks.die_over & die_on;
		cond[alarm_status_pkg::RA_UNDER] = checks.ra_under & ra_on;
		cond[alarm_status_pkg::RA_OVER] = checks.ra_over & ra_on;
		cond[alarm_status_pkg::RB_UNDER] = checks.rb_under & rb_on;
		cond[alarm_status_pkg::RB_OVER] = checks.rb_over & rb_on;
		cond[alarm_status_pkg::RA_FAULT] = checks.ra_fault & ra_on;
		cond[alarm_status_pkg::RB_FAULT] = checks.rb_fault & rb_on;
		cond[alarm_status_pkg::OVERHEAT] = hot_now & die_on;
	end

	// ----------------------------------------------------------------
	// Consecutive-check counters, one per channel
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		for (int i = 0; i < 16; i++) begin
			if (sys_rst | soft_q) begin
				cnt_q[i] <= '0;
			end else if (check_strobe) begin
				if (!cond[i]) begin
					cnt_q[i] <= '0;
				end else if (cnt_q[i] != LAST) begin
					cnt_q[i] <= cnt_q[i] + CW'(1);
				end
			end
		end
	end

	// Qualifying checks this cycle
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			hit[i] = check_strobe & cond[i] & (cnt_q[i] == LAST);
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	always_comb begin
		clr = {16{rd_clr}};
		if (hold_off & check_strobe) begin
			clr = clr | ~cond;
		end
		if (!die_on) begin
			clr[alarm_status_pkg::OVERHEAT] = 1'b1;
		end
		flag_d = ((flag_q & ~clr) | hit) & alarm_status_pkg::STATUS_USED;
	end

	always_ff @(posedge clk) begin
		if (sys_rst | soft_q) begin
			flag_q <= alarm_status_pkg::STATUS_RST;
		end else begin
			flag_q <= flag_d;
		end
	end

	// Alarm pin from unmasked flags
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			alarm_n <= 1'b1;
		end else begin
			alarm_n <= ~(ctrl_q[alarm_status_pkg::CTRL_OUT_EN] & (|(flag_q & mask_q)));
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_set_after_n;
		@(posedge clk) disable iff (sys_rst)
		check_strobe && cond[14] && cnt_q[14] == LAST && !soft_q |=> flag_q[14];
	endproperty
	a_set_after_n: assert property (p_set_after_n) else $error("flag not set after N checks");

	property p_restart;
		@(posedge clk) disable iff (sys_rst)
		check_strobe && !cond[13] |=> cnt_q[13] == '0 && !$rose(flag_q[13]);
	endproperty
	a_restart: assert property (p_restart) else $error("count not restarted");

	property p_latched;
		@(posedge clk) disable iff (sys_rst)
		!hold_off && flag_q[12] && !rd_clr && !soft_q |=> flag_q[12];
	endproperty
	a_latched: assert property (p_latched) else $error("latched flag dropped");

	property p_read_clears;
		@(posedge clk) disable iff (sys_rst)
		rd_clr && hit == 16'h0000 |=> flag_q == 16'h0000;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not clear flags");

	property p_set_wins;
		@(posedge clk) disable iff (sys_rst)
		rd_clr && hit[11] && !soft_q |=> flag_q[11];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost on read");

	property p_follow;
		@(posedge clk) disable iff (sys_rst)
		hold_off && check_strobe && !cond[10] |=> !flag_q[10];
	endproperty
	a_follow: assert property (p_follow) else $error("hold-off flag did not drop");

	property p_reserved;
		@(posedge clk) disable iff (sys_rst)
		av_req.read && !av_waitrequest && reg_sel(av_req.address, alarm_status_pkg::IDX_STATUS) |->
			av_readdata[15] == 1'b0 && av_readdata[1:0] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

	property p_overheat_off;
		@(posedge clk) disable iff (sys_rst)
		!die_on |=> !flag_q[2];
	endproperty
	a_overheat_off: assert property (p_overheat_off) else $error("overheat set while off");

	property p_pin;
		@(posedge clk) disable iff (sys_rst)
		flag_q[9] && mask_q[9] && ctrl_q[0] ##1 !sys_rst |-> !alarm_n;
	endproperty
	a_pin: assert property (p_pin) else $error("alarm pin not driven");

	property p_soft;
		@(posedge clk) disable iff (sys_rst)
		soft_q |=> flag_q == 16'h0000 && cnt_q[14] == '0;
	endproperty
	a_soft: assert property (p_soft) else $error("software reset left flags");

	property p_no_early;
		@(posedge clk) disable iff (sys_rst)
		check_strobe && cnt_q[14] != LAST |=> !$rose(flag_q[14]);
	endproperty
	a_no_early: assert property (p_no_early) else $error("flag set before N checks");

	property p_counts;
		@(posedge clk) disable iff (sys_rst)
		check_strobe && checks.input_oor[0] && cnt_q[14] != LAST && !soft_q |=>
			cnt_q[14] == $past(cnt_q[14]) + CW'(1);
	endproperty
	a_counts: assert property (p_counts) else $error("input count did not advance");

	property p_die_gate;
		@(posedge clk) disable iff (sys_rst)
		check_strobe && !die_on |=> cnt_q[10] == '0 && cnt_q[9] == '0 && !$rose(flag_q[10]);
	endproperty
	a_die_gate: assert property (p_die_gate) else $error("die flags counted while off");

	property p_ra_gate;
		@(posedge clk) disable iff (sys_rst)
		check_strobe && !ra_on |=> cnt_q[8] == '0 && cnt_q[7] == '0 && cnt_q[4] == '0 && !$rose(flag_q[7]);
	endproperty
	a_ra_gate: assert property (p_ra_gate) else $error("remote A counted while off");

	property p_rb_gate;
		@(posedge clk) disable iff (sys_rst)
		check_strobe && !rb_on |=> cnt_q[6] == '0 && cnt_q[5] == '0 && cnt_q[3] == '0 && !$rose(flag_q[6]);
	endproperty
	a_rb_gate: assert property (p_rb_gate) else $error("remote B counted while off");

	property p_masked;
		@(posedge clk) disable iff (sys_rst)
		(flag_q & mask_q) == 16'h0000 |=> alarm_n;
	endproperty
	a_masked: assert property (p_masked) else $error("masked flag drove the pin");

endmodule : alarm_status_flags

// [tb/alarm_host_model.sv]
// Host model: Avalon-MM master that reads and writes the alarm registers.
// Assumes the slave drops waitrequest once per request; requests are held.
module alarm_host_model (
	input wire logic clk, // Bus clock
	output alarm_status_pkg::av_req_t av_req, // Request to the slave
	input wire logic [31:0] av_readdata, // Read data
	input wire logic av_waitrequest // Slave stall
);
	timeunit 1ns;
	timeprecision 1ps;

	initial av_req = '0;

	// One transfer, held until waitrequest is sampled low; the bench watchdog ends a hung wait
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd, output logic [31:0] rd);
		@(posedge clk);
		av_req.read <= !wr;
		av_req.write <= wr;
		av_req.address <= {idx, 2'h0};
		av_req.writedata <= {16'h0000, wd};
		av_req.byteenable <= 4'hF;
		do begin
			@(posedge clk);
		end while (av_waitrequest !== 1'h0);
		rd = av_readdata;
		av_req.read <= 1'h0;
		av_req.write <= 1'h0;
	endtask : xfer
endmodule : alarm_host_model

// [tb/alarm_status_flags_tb_top.sv]
// Self-checking bench for the alarm status flags, with a reference model.
// Assumes the host model as bus master and a 100 MHz clock.
module alarm_status_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int N = 2;
	logic clk, sys_rst, stb, alarm_n, wreq;
	logic [31:0] rdata, rd;
	alarm_status_pkg::av_req_t req;
	alarm_status_pkg::check_t cv;
	logic signed [11:0] temp;
	int fails, checks_done, seed, cnt[16];
	logic [15:0] flags, ctrl, mask, raw;
	logic hot;

	alarm_status_flags #(.CHECK_COUNT(N)) dut (.clk(clk), .sys_rst(sys_rst), .av_req(req),
		.av_readdata(rdata), .av_waitrequest(wreq), .check_strobe(stb), .checks(cv),
		.die_temp(temp), .alarm_n(alarm_n));
	alarm_host_model host (.clk(clk), .av_req(req), .av_readdata(rdata), .av_waitrequest(wreq));

	// Clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out();
		if (fails == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out

	// Status bits 14 to 3 that are checked under the given control word
	function automatic logic [15:0] live_mask(input logic [15:0] c);
		return {1'h0, 4'hF, {2{c[3]}}, {2{c[4]}}, {2{c[5]}}, c[4], c[5], 3'h0};
	endfunction : live_mask

	// Drive one conversion result; the strobe is seen at the next edge
	task automatic drive(input logic [15:0] flip);
		raw ^= 16'h7FF8 & flip;
		@(posedge clk);
		stb <= 1'h1;
		cv <= {raw[11], raw[12], raw[13], raw[14], raw[10:3]};
		temp <= 12'(130 + $unsigned($random(seed)) % 30);
	endtask : drive

	// Model of one conversion result at its strobe edge
	task automatic model_step();
		logic [15:0] live;
		hot = ctrl[3] && (temp >= alarm_status_pkg::OVERHEAT_C ||
			(hot && temp >= alarm_status_pkg::OVERHEAT_C - alarm_status_pkg::OVERHEAT_HYST_C));
		live = raw & live_mask(ctrl);
		live[2] = hot;
		for (int b = 2; b < 15; b++) begin
			if (live[b]) begin
				cnt[b] = (cnt[b] < N) ? cnt[b] + 1 : N;
				if (cnt[b] == N) flags[b] = 1'h1;
			end else begin
				cnt[b] = 0;
				if (ctrl[2]) flags[b] = 1'h0;
			end
		end
	endtask : model_step

	// Pin check one edge after the strobe edge
	task automatic pin_check();
		@(posedge clk);
		#1;
		check("alarm pin", {31'h0, alarm_n}, {31'h0, !(ctrl[0] && |(flags & mask))});
	endtask : pin_check

	// One conversion result, then model update and pin check
	task automatic strobe(input logic [15:0] flip);
		drive(flip);
		@(posedge clk);
		stb <= 1'h0;
		model_step();
		pin_check();
	endtask : strobe

	// Status read whose completing edge meets a strobe; the set must win
	task automatic read_hit(input logic [15:0] flip);
		logic [15:0] old;
		old = flags;
		fork
			host.xfer(1'h0, alarm_status_pkg::IDX_STATUS, 16'h0000, rd);
			begin
				@(posedge clk);
				drive(flip);
			end
		join
		stb <= 1'h0;
		check("status", rd, {16'h0000, old});
		flags = 16'h0000;
		model_step();
		pin_check();
	endtask : read_hit

	// Status read; the model clears all flags with it
	task automatic read_status();
		host.xfer(1'h0, alarm_status_pkg::IDX_STATUS, 16'h0000, rd);
		check("status", rd, {16'h0000, flags});
		flags = 16'h0000;
	endtask : read_status

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 57423;
		sys_rst = 1'h1;
		stb = 1'h0;
		cv = '0;
		temp = '0;
		{flags, raw, ctrl, mask} = '0;
		hot = 1'h0;
		fails = 0;
		checks_done = 0;
		foreach (cnt[i]) cnt[i] = 0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'h0;
		// Reset values of ctrl, mask, status and one unmapped index
		for (int i = 0; i < 4; i++) begin
			host.xfer(1'h0, 8'h4D + 8'(i), 16'h0000, rd);
			check("reset value", rd, 32'h0000_0000);
		end
		host.xfer(1'h1, alarm_status_pkg::IDX_STATUS, 16'hFFFF, rd);
		read_status();
		// Random traffic under several control settings
		for (int m = 0; m < 6; m++) begin
			ctrl = 16'($random(seed)) & 16'h0039;
			if (m < 2) ctrl = 16'h0039;
			ctrl[2] = m[0];
			mask = 16'($random(seed)) & 16'h7FFC;
			host.xfer(1'h1, alarm_status_pkg::IDX_CTRL, ctrl, rd);
			host.xfer(1'h1, alarm_status_pkg::IDX_MASK, mask, rd);
			host.xfer(1'h0, alarm_status_pkg::IDX_CTRL, 16'h0000, rd);
			check("control", rd, {16'h0000, ctrl});
			host.xfer(1'h0, alarm_status_pkg::IDX_MASK, 16'h0000, rd);
			check("mask", rd, {16'h0000, mask});
			repeat (40) begin
				case ($random(seed) & 7)
					0, 1: read_status();
					2: read_hit(16'($random(seed) & $random(seed) & $random(seed)));
					default: strobe(16'($random(seed) & $random(seed) & $random(seed)));
				endcase
			end
			// Software reset clears flags and counts
			host.xfer(1'h1, alarm_status_pkg::IDX_CTRL, ctrl | 16'h8000, rd);
			foreach (cnt[i]) cnt[i] = 0;
			flags = '0;
			hot = 1'h0;
			repeat (2) @(posedge clk);
			read_status();
		end
		// Hardware reset in mid-run with every flag of bits 14 to 3 that the control word enables set
		raw = 16'h7FF8;
		repeat (N) strobe(16'h0000);
		read_hit(16'h0000);
		@(posedge clk);
		sys_rst <= 1'h1;
		@(posedge clk);
		sys_rst <= 1'h0;
		{flags, ctrl, mask} = '0;
		hot = 1'h0;
		foreach (cnt[i]) cnt[i] = 0;
		@(posedge clk);
		#1;
		check("alarm pin", {31'h0, alarm_n}, 32'h0000_0001);
		read_status();
		close_out();
	end

	// Watchdog against a hung handshake
	initial begin
		#200000;
		fails++;
		close_out();
	end
endmodule : alarm_status_flags_tb_top
